// >>> rtl/dvx_defs.svh
`ifndef DVX_DEFS_SVH
`define DVX_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define DVX_ADDR_CTRL 8'h00
`define DVX_ADDR_ROUTE 8'h04
`define DVX_ADDR_STATUS 8'h08
`define DVX_ADDR_IRQ_STAT 8'h0C
`define DVX_ADDR_IRQ_CLR 8'h10
`define DVX_ADDR_IRQ_EN 8'h14

////////////////////////////////////////////////////////////////////////////////
// field positions
`define DVX_CTRL_AUTO_BIT 0
`define DVX_CTRL_FORCE_BIT 1
`define DVX_ROUTE_OUT1_BIT 0
`define DVX_ROUTE_OUT2_BIT 1
`define DVX_STAT_PRESENT_LSB 0
`define DVX_STAT_ROUTE_LSB 2
`define DVX_STAT_FAULT_BIT 4
`define DVX_STAT_AUTO_BIT 5
`define DVX_IRQ_SYNC_LSB 0
`define DVX_IRQ_FALLBACK_LSB 2
`define DVX_IRQ_FAULT_BIT 4
`define DVX_IRQ_W 5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define DVX_CTRL_RST 1'b1
`define DVX_ROUTE_RST 2'h2
`define DVX_IRQ_EN_RST 5'h00

////////////////////////////////////////////////////////////////////////////////
// timing
`define DVX_CLK_HZ 10000000
`define DVX_SYNC_LOSS_US 100000
`define DVX_SYNC_LOSS_CYC (`DVX_SYNC_LOSS_US * (`DVX_CLK_HZ / 1000000))

`endif

// >>> rtl/dvx_ind_if.sv
interface dvx_ind_if;
	logic [1:0] present;
	logic [1:0] route;
	logic fault;

	modport core (
		output present,
		output route,
		output fault
	);

	modport led (
		input present,
		input route,
		input fault
	);
endinterface : dvx_ind_if

// >>> rtl/dvx_led_drv.sv
module dvx_led_drv (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	dvx_ind_if.led ind, // presence, routing and fault state
	output logic led_in1_green_o, // input 1 signal lamp
	output logic led_in2_orange_o, // input 2 signal lamp
	output logic [1:0] led_out_green_o, // output k carries input 1
	output logic [1:0] led_out_orange_o, // output k carries input 2
	output logic led_power_o // on while healthy
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_in1_green_o <= 1'b0;
			led_in2_orange_o <= 1'b0;
			led_out_green_o <= 2'h0;
			led_out_orange_o <= 2'h0;
			led_power_o <= 1'b0;
		end else begin
			led_in1_green_o <= ind.present[0];
			led_in2_orange_o <= ind.present[1];
			led_out_green_o <= ~ind.route;
			led_out_orange_o <= ind.route;
			led_power_o <= ~ind.fault;
		end
	end
endmodule : dvx_led_drv

// >>> rtl/dvx_pkg.sv
package dvx_pkg;

	typedef enum logic {
		dvx_src_in1,
		dvx_src_in2
	} dvx_src_t;

	typedef enum {
		dvx_hl_init,
		dvx_hl_run,
		dvx_hl_fault
	} dvx_health_t;

endpackage : dvx_pkg

// >>> rtl/dvx_sync_det.sv
`include "dvx_defs.svh"

module dvx_sync_det #(
	parameter int unsigned LOSS_CYC = `DVX_SYNC_LOSS_CYC
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic vsync_i, // already synchronised vertical sync
	output logic present_o, // sync seen recently
	output logic change_o // one-cycle pulse on presence change
);
	localparam int unsigned CW = $clog2(LOSS_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(LOSS_CYC - 1);

	logic vs_d_reg;
	logic [CW-1:0] cnt_reg;
	logic present_reg;
	logic present_next;
	logic chg_reg;
	wire edge_seen = vsync_i & ~vs_d_reg;

	// presence drops only after a whole loss interval without a sync edge
	assign present_next = edge_seen ? 1'b1 : ((cnt_reg == LAST) ? 1'b0 : present_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vs_d_reg <= 1'b0;
			cnt_reg <= '0;
			present_reg <= 1'b0;
			chg_reg <= 1'b0;
		end else begin
			vs_d_reg <= vsync_i;
			cnt_reg <= (edge_seen || !present_reg || cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
			present_reg <= present_next;
			chg_reg <= present_next ^ present_reg;
		end
	end

	assign present_o = present_reg;
	assign change_o = chg_reg;
endmodule : dvx_sync_det

// >>> rtl/dvx_top.sv
`include "dvx_defs.svh"

// Notes on behaviour
// - each output may be routed to either input independently
// - both outputs may carry the same input at once
// - assignment changes only by route register write, or by automatic fallback
// - an input counts as live while sync is detected; its lamp follows that
// - input 1 lamp green while input 1 live, dark otherwise
// - input 2 lamp orange while input 2 live, dark otherwise
// - output 1 lamp green carrying input 1, orange carrying input 2
// - output 2 lamp green carrying input 1, orange carrying input 2
// - power lamp lit while running, dark once control logic detects an error
// - fallback enabled after reset, software can disable it
// - without explicit selection, input 1 feeds output 1, input 2 output 2
// - fallback on: output whose assigned input is dead takes the other input
module dvx_top #(
	parameter int unsigned DATA_W = 24,
	parameter int unsigned SYNC_LOSS_CYC = `DVX_SYNC_LOSS_CYC
) (
	input wire logic clk_i, // 10 MHz system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte enables
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic [DATA_W-1:0] vin1_data_i, // input 1 pixel data
	input wire logic vin1_de_i, // input 1 data enable
	input wire logic vin1_hs_i, // input 1 horizontal sync
	input wire logic vin1_vs_i, // input 1 vertical sync
	input wire logic [DATA_W-1:0] vin2_data_i, // input 2 pixel data
	input wire logic vin2_de_i, // input 2 data enable
	input wire logic vin2_hs_i, // input 2 horizontal sync
	input wire logic vin2_vs_i, // input 2 vertical sync
	output logic [DATA_W-1:0] vout1_data_o, // output 1 pixel data
	output logic vout1_de_o, // output 1 data enable
	output logic vout1_hs_o, // output 1 horizontal sync
	output logic vout1_vs_o, // output 1 vertical sync
	output logic [DATA_W-1:0] vout2_data_o, // output 2 pixel data
	output logic vout2_de_o, // output 2 data enable
	output logic vout2_hs_o, // output 2 horizontal sync
	output logic vout2_vs_o, // output 2 vertical sync
	output logic led_in1_green_o, // input 1 lamp
	output logic led_in2_orange_o, // input 2 lamp
	output logic led_out1_green_o, // output 1 lamp, green
	output logic led_out1_orange_o, // output 1 lamp, orange
	output logic led_out2_green_o, // output 2 lamp, green
	output logic led_out2_orange_o, // output 2 lamp, orange
	output logic led_power_o, // power lamp
	output logic irq_o // level interrupt, high
);
	localparam int unsigned VW = DATA_W + 3;
	localparam int unsigned IW = `DVX_IRQ_W;
	// reset route as a vector so each output can pick its own bit
	localparam logic [1:0] ROUTE_RST = `DVX_ROUTE_RST;

	////////////////////////////////////////////////////////////////////////////
	// video input synchronisers and sync detection

	logic [VW-1:0] vin_raw [2];
	logic [VW-1:0] vin_s1_reg [2];
	logic [VW-1:0] vin_s2_reg [2];
	logic [1:0] present;
	logic [1:0] present_chg;

	assign vin_raw[0] = {vin1_vs_i, vin1_hs_i, vin1_de_i, vin1_data_i};
	assign vin_raw[1] = {vin2_vs_i, vin2_hs_i, vin2_de_i, vin2_data_i};

	// the whole word crosses together; pixel data is only as good as a
	// sampled copy, sync detection is what this path is really for
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					vin_s1_reg[gi] <= '0;
					vin_s2_reg[gi] <= '0;
				end else begin
					vin_s1_reg[gi] <= vin_raw[gi];
					vin_s2_reg[gi] <= vin_s1_reg[gi];
				end
			end

			dvx_sync_det #(
				.LOSS_CYC(SYNC_LOSS_CYC)
			) u_det (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.vsync_i(vin_s2_reg[gi][VW-1]),
				.present_o(present[gi]),
				.change_o(present_chg[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// wishbone decode

	logic ack_reg;
	logic [31:0] rdat_reg;
	// ack is registered: masking with it keeps a strobe still high in the
	// ack cycle from being taken a second time
	wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// every field sits in the low byte, so only lane 0 can write
	wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
	wire rd_req = req & ~wb_we_i;

	wire hit_ctrl = (wb_adr_i == `DVX_ADDR_CTRL);
	wire hit_route = (wb_adr_i == `DVX_ADDR_ROUTE);
	wire hit_status = (wb_adr_i == `DVX_ADDR_STATUS);
	wire hit_istat = (wb_adr_i == `DVX_ADDR_IRQ_STAT);
	wire hit_iclr = (wb_adr_i == `DVX_ADDR_IRQ_CLR);
	wire hit_ien = (wb_adr_i == `DVX_ADDR_IRQ_EN);

	wire wr_ctrl = wr_lane0 & hit_ctrl;
	wire wr_route = wr_lane0 & hit_route;
	wire wr_iclr = wr_lane0 & hit_iclr;
	wire wr_ien = wr_lane0 & hit_ien;

	////////////////////////////////////////////////////////////////////////////
	// control and routing state

	logic auto_reg;
	logic force_reg;
	dvx_pkg::dvx_src_t assign_reg [2];
	dvx_pkg::dvx_src_t shadow_reg [2];
	dvx_pkg::dvx_src_t route_reg [2];
	dvx_pkg::dvx_src_t route_next [2];
	// last cycle's fallback state, for the began-edge interrupt
	logic [1:0] fb_reg;
	logic [1:0] fb_next;
	logic [1:0] route_bits;
	logic [1:0] assign_bits;
	logic [1:0] shadow_bits;
	logic [1:0] wr_route_bits;

	assign wr_route_bits = {wb_dat_i[`DVX_ROUTE_OUT2_BIT], wb_dat_i[`DVX_ROUTE_OUT1_BIT]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_reg <= `DVX_CTRL_RST;
			force_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				auto_reg <= wb_dat_i[`DVX_CTRL_AUTO_BIT];
			end
			force_reg <= wr_ctrl & wb_dat_i[`DVX_CTRL_FORCE_BIT];
		end
	end

	generate
		for (gi = 0; gi < 2; gi++) begin : g_out
			// fallback is considered against the assigned input, never against
			// the current fallback choice, so two dead inputs cannot ping-pong
			assign fb_next[gi] = auto_reg & ~present[assign_bits[gi]];
			assign route_next[gi] = fb_next[gi] ? dvx_pkg::dvx_src_t'(~assign_bits[gi]) : assign_reg[gi];
			assign route_bits[gi] = route_reg[gi];
			assign assign_bits[gi] = assign_reg[gi];
			assign shadow_bits[gi] = shadow_reg[gi];

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					assign_reg[gi] <= dvx_pkg::dvx_src_t'(ROUTE_RST[gi]);
					shadow_reg[gi] <= dvx_pkg::dvx_src_t'(ROUTE_RST[gi]);
					route_reg[gi] <= dvx_pkg::dvx_src_t'(ROUTE_RST[gi]);
					fb_reg[gi] <= 1'b0;
				end else begin
					if (wr_route) begin
						assign_reg[gi] <= dvx_pkg::dvx_src_t'(wr_route_bits[gi]);
						shadow_reg[gi] <= dvx_pkg::dvx_src_t'(wr_route_bits[gi]);
					end
					route_reg[gi] <= route_next[gi];
					fb_reg[gi] <= fb_next[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// video crossbar

	logic [VW-1:0] vout_reg [2];

	generate
		for (gi = 0; gi < 2; gi++) begin : g_xbar
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					vout_reg[gi] <= '0;
				end else begin
					// two outputs may index the same input word at once
					vout_reg[gi] <= vin_s2_reg[route_bits[gi]];
				end
			end
		end
	endgenerate

	assign {vout1_vs_o, vout1_hs_o, vout1_de_o, vout1_data_o} = vout_reg[0];
	assign {vout2_vs_o, vout2_hs_o, vout2_de_o, vout2_data_o} = vout_reg[1];

	////////////////////////////////////////////////////////////////////////////
	// health monitor

	dvx_pkg::dvx_health_t hl_reg;
	dvx_pkg::dvx_health_t hl_next;
	logic fault_d_reg;
	logic route_wr_d_reg;
	wire mismatch = (assign_bits != shadow_bits);
	// with fallback off the output must follow the assignment exactly; the
	// route register trails a route write by one cycle, so that cycle and the
	// write cycle itself are not judged
	wire route_bad = ~auto_reg & ~fb_reg[0] & ~fb_reg[1] & (route_bits != assign_bits)
		& ~wr_route & ~route_wr_d_reg;
	wire fault = (hl_reg == dvx_pkg::dvx_hl_fault);
	// no way out of fault short of reset: a dark lamp stays until someone looks
	wire fault_began = fault & ~fault_d_reg;

	always_comb begin
		hl_next = hl_reg;
		case (hl_reg)
			dvx_pkg::dvx_hl_init: begin
				hl_next = mismatch ? dvx_pkg::dvx_hl_fault : dvx_pkg::dvx_hl_run;
			end
			dvx_pkg::dvx_hl_run: begin
				if (mismatch || force_reg || route_bad) begin
					hl_next = dvx_pkg::dvx_hl_fault;
				end
			end
			dvx_pkg::dvx_hl_fault: begin
				hl_next = dvx_pkg::dvx_hl_fault;
			end
			default: begin
				hl_next = dvx_pkg::dvx_hl_fault;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hl_reg <= dvx_pkg::dvx_hl_init;
			fault_d_reg <= 1'b0;
			route_wr_d_reg <= 1'b0;
		end else begin
			hl_reg <= hl_next;
			fault_d_reg <= fault;
			route_wr_d_reg <= wr_route;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	logic [IW-1:0] irq_stat_reg;
	logic [IW-1:0] irq_en_reg;
	logic [IW-1:0] irq_set;
	logic [IW-1:0] irq_clr;
	logic [1:0] fb_began;

	assign fb_began = fb_next & ~fb_reg;
	assign irq_set = {fault_began, fb_began, present_chg};
	assign irq_clr = wr_iclr ? wb_dat_i[IW-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_en_reg <= `DVX_IRQ_EN_RST;
		end else begin
			// a new event in the clearing cycle survives the clear
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr_ien) begin
				irq_en_reg <= wb_dat_i[IW-1:0];
			end
		end
	end

	// level output: it stays high until software clears the status bit
	assign irq_o = |(irq_stat_reg & irq_en_reg);

	////////////////////////////////////////////////////////////////////////////
	// read mux and acknowledge

	logic [31:0] rd_mux;
	logic [31:0] stat_word;

	assign stat_word = {26'h000_0000, auto_reg, fault, route_bits, present};

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = {31'h0000_0000, auto_reg};
		end else if (hit_route) begin
			rd_mux = {30'h0000_0000, assign_bits};
		end else if (hit_status) begin
			rd_mux = stat_word;
		end else if (hit_istat) begin
			rd_mux = {27'h000_0000, irq_stat_reg};
		end else if (hit_iclr) begin
			// the clear register is write-only and reads as zero
			rd_mux = 32'h0000_0000;
		end else if (hit_ien) begin
			rd_mux = {27'h000_0000, irq_en_reg};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			rdat_reg <= rd_req ? rd_mux : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	////////////////////////////////////////////////////////////////////////////
	// front-panel lamps

	// lamps trail the route by one cycle, as the video mux does
	dvx_ind_if ind ();
	logic [1:0] led_og;
	logic [1:0] led_oo;

	assign ind.present = present;
	assign ind.route = route_bits;
	assign ind.fault = fault;

	dvx_led_drv u_led (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ind(ind.led),
		.led_in1_green_o(led_in1_green_o),
		.led_in2_orange_o(led_in2_orange_o),
		.led_out_green_o(led_og),
		.led_out_orange_o(led_oo),
		.led_power_o(led_power_o)
	);

	assign led_out1_green_o = led_og[0];
	assign led_out2_green_o = led_og[1];
	assign led_out1_orange_o = led_oo[0];
	assign led_out2_orange_o = led_oo[1];

endmodule : dvx_top

// >>> tb/dvx_chk.sv
`include "dvx_defs.svh"

module dvx_chk #(
	parameter int unsigned DATA_W = 24,
	parameter int unsigned SYNC_LOSS_CYC = 20
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // bus
	input wire logic wb_stb_i, // bus
	input wire logic wb_we_i, // bus
	input wire logic [7:0] wb_adr_i, // bus
	input wire logic [3:0] wb_sel_i, // bus
	input wire logic [31:0] wb_dat_i, // bus
	input wire logic [31:0] wb_dat_o, // bus
	input wire logic wb_ack_o, // bus
	input wire logic [DATA_W-1:0] vin1_data_i, // video
	input wire logic [DATA_W-1:0] vin2_data_i, // video
	input wire logic vin1_vs_i, // video
	input wire logic vin2_vs_i, // video
	input wire logic [DATA_W-1:0] vout1_data_o, // video
	input wire logic [DATA_W-1:0] vout2_data_o, // video
	input wire logic led_in1_green_o, // lamp
	input wire logic led_in2_orange_o, // lamp
	input wire logic led_out1_green_o, // lamp
	input wire logic led_out1_orange_o, // lamp
	input wire logic led_out2_green_o, // lamp
	input wire logic led_out2_orange_o, // lamp
	input wire logic led_power_o // lamp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	int unsigned c1_reg, c2_reg;
	wire taken_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// cycles since the last sync pin high, saturating past the loss time
	always_ff @(posedge clk_i) begin
		c1_reg <= (rst_i || vin1_vs_i) ? 0 : (c1_reg < SYNC_LOSS_CYC + 8) ? c1_reg + 1 : c1_reg;
		c2_reg <= (rst_i || vin2_vs_i) ? 0 : (c2_reg < SYNC_LOSS_CYC + 8) ? c2_reg + 1 : c2_reg;
	end
	property p_ack_lat; taken_w |=> wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("request not answered next cycle");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	property p_lamp1; !$past(rst_i) |-> led_out1_green_o ^ led_out1_orange_o; endproperty
	a_lamp1: assert property (p_lamp1) else $error("output 1 lamp not one colour");
	property p_lamp2; !$past(rst_i) |-> led_out2_green_o ^ led_out2_orange_o; endproperty
	a_lamp2: assert property (p_lamp2) else $error("output 2 lamp not one colour");
	property p_loss1; c1_reg == SYNC_LOSS_CYC + 8 |-> !led_in1_green_o; endproperty
	a_loss1: assert property (p_loss1) else $error("input 1 lamp lit without sync");
	property p_loss2; c2_reg == SYNC_LOSS_CYC + 8 |-> !led_in2_orange_o; endproperty
	a_loss2: assert property (p_loss2) else $error("input 2 lamp lit without sync");
	property p_vid1;
		led_out1_green_o && !$past(rst_i, 4) |-> vout1_data_o == $past(vin1_data_i, 3);
	endproperty
	a_vid1: assert property (p_vid1) else $error("output 1 not carrying input 1");
	property p_vid2;
		led_out2_orange_o && !$past(rst_i, 4) |-> vout2_data_o == $past(vin2_data_i, 3);
	endproperty
	a_vid2: assert property (p_vid2) else $error("output 2 not carrying input 2");
	property p_force;
		taken_w && wb_we_i && wb_adr_i == `DVX_ADDR_CTRL && wb_sel_i[0] && wb_dat_i[1] |-> ##[2:4] !led_power_o;
	endproperty
	a_force: assert property (p_force) else $error("power lamp lit after fault");
	c_swap: cover property (led_out1_orange_o && led_out2_green_o);
	c_dup: cover property (led_out1_orange_o && led_out2_orange_o);
	c_fault: cover property ($fell(led_power_o));
endmodule : dvx_chk

bind dvx_top dvx_chk #(.DATA_W(DATA_W), .SYNC_LOSS_CYC(SYNC_LOSS_CYC)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vin1_data_i, .vin2_data_i,
	.vin1_vs_i, .vin2_vs_i, .vout1_data_o, .vout2_data_o, .led_in1_green_o, .led_in2_orange_o,
	.led_out1_green_o, .led_out1_orange_o, .led_out2_green_o, .led_out2_orange_o, .led_power_o);

// >>> tb/dvx_src_model.sv
module dvx_src_model #(
	parameter int unsigned DATA_W = 24,
	parameter logic [7:0] BASE = 8'h00
) (
	input wire logic clk_i, // system clock
	input wire logic en_i, // source sends sync
	output logic [DATA_W-1:0] data_o, // pixel data
	output logic de_o, // data enable
	output logic hs_o, // horizontal sync
	output logic vs_o // vertical sync
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;
	initial begin
		data_o = '0;
		de_o = 1'h0;
		hs_o = 1'h0;
		vs_o = 1'h0;
	end
	// data changes every cycle so a stale mux shows up at once
	always @(posedge clk_i) begin
		cnt <= cnt + 8'h01;
		data_o <= {(DATA_W / 8){cnt ^ BASE}};
		de_o <= cnt[1];
		hs_o <= cnt[2:0] == 3'h0;
		vs_o <= en_i && cnt[2:0] == 3'h3;
	end
endmodule : dvx_src_model

// >>> tb/tb.sv
`include "dvx_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, en1 = 1'h0, en2 = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0, sel_v = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [23:0] vin1_data_i, vin2_data_i, vout1_data_o, vout2_data_o;
	logic vin1_de_i, vin1_hs_i, vin1_vs_i, vin2_de_i, vin2_hs_i, vin2_vs_i, wb_ack_o, irq_o, led_power_o;
	logic vout1_de_o, vout1_hs_o, vout1_vs_o, vout2_de_o, vout2_hs_o, vout2_vs_o;
	logic led_in1_green_o, led_in2_orange_o, led_out1_green_o, led_out1_orange_o, led_out2_green_o, led_out2_orange_o;
	int fails = 0, n_tests = 0;
	wire [3:0] lamp_w = {led_out2_orange_o, led_out2_green_o, led_out1_orange_o, led_out1_green_o};
	dvx_top #(.SYNC_LOSS_CYC(20)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vin1_data_i, .vin1_de_i, .vin1_hs_i,
		.vin1_vs_i, .vin2_data_i, .vin2_de_i, .vin2_hs_i, .vin2_vs_i, .vout1_data_o, .vout1_de_o,
		.vout1_hs_o, .vout1_vs_o, .vout2_data_o, .vout2_de_o, .vout2_hs_o, .vout2_vs_o, .led_in1_green_o,
		.led_in2_orange_o, .led_out1_green_o, .led_out1_orange_o, .led_out2_green_o, .led_out2_orange_o,
		.led_power_o, .irq_o);
	dvx_src_model #(.BASE(8'h00)) u_src1 (.clk_i, .en_i(en1), .data_o(vin1_data_i),
		.de_o(vin1_de_i), .hs_o(vin1_hs_i), .vs_o(vin1_vs_i));
	dvx_src_model #(.BASE(8'ha5)) u_src2 (.clk_i, .en_i(en2), .data_o(vin2_data_i),
		.de_o(vin2_de_i), .hs_o(vin2_hs_i), .vs_o(vin2_vs_i));
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			$display("BAD %s exp %h got %h", nm, e, s);
			fails++;
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel_v;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1 && n++ < 20);
		q = wb_dat_o;
		if (wb_ack_o !== 1'h1) chk("ack", 1'h1, 1'h0);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask : wb
	function automatic logic [3:0] lamps(input logic [1:0] r);
		return {r[1], ~r[1], r[0], ~r[0]};
	endfunction : lamps
	task automatic t_reset;
		chk("power", 1'h1, led_power_o);
		chk("in lamps", 2'h0, {led_in2_orange_o, led_in1_green_o});
		chk("lamps", lamps(2'h1), lamp_w);
		wb(1'h0, `DVX_ADDR_IRQ_STAT, 32'h0);
		chk("irq stat", 4'hc, q & 32'h0000_000c);
		wb(1'h0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask : t_reset
	task automatic t_live;
		en1 <= 1'h1;
		en2 <= 1'h1;
		repeat (30) @(posedge clk_i);
		chk("in lamps", 2'h3, {led_in2_orange_o, led_in1_green_o});
		chk("lamps", lamps(2'h2), lamp_w);
		// a write without lane 0 must leave fallback enabled
		sel_v = 4'he;
		wb(1'h1, `DVX_ADDR_CTRL, 32'h0);
		sel_v = 4'hf;
		wb(1'h0, `DVX_ADDR_CTRL, 32'h0);
		chk("auto", 1'h1, q[0]);
	endtask : t_live
	task automatic t_route;
		for (int r = 0; r < 4; r++) begin
			wb(1'h1, `DVX_ADDR_ROUTE, r);
			repeat (3) @(posedge clk_i);
			chk("lamps", lamps(r[1:0]), lamp_w);
			wb(1'h0, `DVX_ADDR_STATUS, 32'h0);
			chk("route", r, q[3:2]);
		end
	endtask : t_route
	task automatic t_fallback;
		wb(1'h1, `DVX_ADDR_ROUTE, 2'h2);
		wb(1'h1, `DVX_ADDR_IRQ_CLR, 5'h1f);
		wb(1'h1, `DVX_ADDR_IRQ_EN, 5'h04);
		en1 <= 1'h0;
		repeat (40) @(posedge clk_i);
		chk("lamps", lamps(2'h3), lamp_w);
		chk("in1 lamp", 1'h0, led_in1_green_o);
		chk("irq", 1'h1, irq_o);
		wb(1'h1, `DVX_ADDR_IRQ_CLR, 5'h04);
		@(posedge clk_i);
		chk("irq", 1'h0, irq_o);
		wb(1'h1, `DVX_ADDR_CTRL, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("lamps", lamps(2'h2), lamp_w);
		wb(1'h0, `DVX_ADDR_STATUS, 32'h0);
		chk("auto", 1'h0, q[5]);
		// a route write with fallback off must not look like a control error
		wb(1'h1, `DVX_ADDR_ROUTE, 32'h1);
		repeat (3) @(posedge clk_i);
		chk("lamps", lamps(2'h1), lamp_w);
		chk("power", 1'h1, led_power_o);
		en1 <= 1'h1;
	endtask : t_fallback
	task automatic t_fault;
		wb(1'h1, `DVX_ADDR_CTRL, 2'h3);
		repeat (4) @(posedge clk_i);
		chk("power", 1'h0, led_power_o);
		wb(1'h0, `DVX_ADDR_STATUS, 32'h0);
		chk("fault", 1'h1, q[4]);
		wb(1'h0, `DVX_ADDR_IRQ_STAT, 32'h0);
		chk("fault irq", 1'h1, q[4]);
		// only a reset leaves the fault state
		rst_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk("power", 1'h1, led_power_o);
		wb(1'h0, `DVX_ADDR_ROUTE, 32'h0);
		chk("route", 2'h2, q[1:0]);
		wb(1'h0, `DVX_ADDR_CTRL, 32'h0);
		chk("auto", 1'h1, q[0]);
	endtask : t_fault
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// the whole run is well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (5) @(posedge clk_i);
		t_reset;
		t_live;
		t_route;
		t_fallback;
		t_fault;
		stop_test;
	end
endmodule : tb
